// >>> common/spc_pkg.sv
// spc_pkg: shared constants and carrier types for the sleep/idle power controller
package spc_pkg;

  // ********************************************************************
  // power-save instruction operand encoding
  // ********************************************************************
  localparam logic [7:0] SPC_OP_SLEEP = 8'h00;
  localparam logic [7:0] SPC_OP_IDLE = 8'h01;

  // ********************************************************************
  // widths and reset values
  // ********************************************************************
  localparam int SPC_IO_W = 16;
  localparam int SPC_OSC_W = 3;
  localparam logic [2:0] SPC_OSC_RST = 3'h0;
  localparam logic [15:0] SPC_IO_RST = 16'h0000;

  // ********************************************************************
  // carrier types
  // ********************************************************************
  typedef struct packed {
    logic valid;
    logic [7:0] operand;
  } spc_cmd_t;

  typedef struct packed {
    logic irqReq;
    logic wdtTimeout;
    logic anyReset;
  } spc_wake_t;

  typedef struct packed {
    logic [SPC_IO_W-1:0] dir;
    logic [SPC_IO_W-1:0] out;
  } spc_io_t;

  typedef enum logic [2:0] {
    SPC_RUN = 3'b001,
    SPC_IDLE = 3'b010,
    SPC_SLEEP = 3'b100
  } spc_state_t;

endpackage

// >>> hdl/spc_io_hold.sv
// spc_io_hold: freezes pin direction and output state while a hold is active
`timescale 1ns/1ps
module spc_io_hold
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hold,
  input wire spc_io_t ioIn,
  output spc_io_t ioOut
);

  spc_io_t io_reg;
  spc_io_t io_next;

  // ********************************************************************
  // latch: follow live value unless frozen
  // ********************************************************************
  assign io_next = hold ? io_reg : ioIn;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      io_reg <= '{dir: SPC_IO_RST, out: SPC_IO_RST};
    end else begin
      io_reg <= io_next;
    end
  end

  assign ioOut = io_reg;

endmodule

// >>> hdl/spc_power_ctrl.sv
// spc_power_ctrl: sleep/idle mode control and clock gating for the core and peripherals
`timescale 1ns/1ps

module spc_power_ctrl
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire spc_cmd_t pwrSaveCmd,
  input wire spc_wake_t wakeIn,
  input wire logic wdtEnable,
  input wire logic calEnable,
  input wire logic calUsesRc,
  input wire logic oscWrite,
  input wire logic [SPC_OSC_W-1:0] oscWriteSel,
  input wire logic oscLocked,
  input wire spc_io_t ioLive,
  output spc_io_t ioPins,
  output logic cpuRun,
  output logic sysClkEn,
  output logic periphClkEn,
  output logic oscEnable,
  output logic [SPC_OSC_W-1:0] curOscSel,
  output logic clkMonEnable,
  output logic rcClkEnable,
  output logic wdtClear,
  output logic irqService,
  output logic [1:0] modeOut
);

  // ********************************************************************
  // input synchronisers for external wake events
  // ********************************************************************
  spc_wake_t wakeMeta_reg;
  spc_wake_t wakeSync_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wakeMeta_reg <= '0;
      wakeSync_reg <= '0;
    end else begin
      wakeMeta_reg <= wakeIn;
      wakeSync_reg <= wakeMeta_reg;
    end
  end

  // ********************************************************************
  // mode state machine
  // ********************************************************************
  spc_state_t state_reg;
  spc_state_t state_next;
  logic [SPC_OSC_W-1:0] osc_reg;
  logic [SPC_OSC_W-1:0] osc_next;
  logic [SPC_OSC_W-1:0] sleepOsc_reg;
  logic wdtClr_reg;
  logic irqSvc_reg;

  // ********************************************************************
  // command decode
  // ********************************************************************
  function automatic logic opMatch(input spc_cmd_t cmd, input logic [7:0] code);
    return cmd.valid && (cmd.operand == code);
  endfunction

  wire logic wakeAny = wakeSync_reg.irqReq | wakeSync_reg.wdtTimeout
                       | wakeSync_reg.anyReset;
  wire logic enterSleep = opMatch(pwrSaveCmd, SPC_OP_SLEEP);
  wire logic enterIdle = opMatch(pwrSaveCmd, SPC_OP_IDLE);
  wire logic inRun = (state_reg == SPC_RUN);
  wire logic inSleep = (state_reg == SPC_SLEEP);
  // a write in the sleep-entry cycle is dropped so wake resumes the entry source
  wire logic oscWriteOk = oscWrite && !oscLocked && inRun && !enterSleep;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SPC_RUN: begin
        if (enterSleep) begin
          state_next = SPC_SLEEP;
        end else if (enterIdle) begin
          state_next = SPC_IDLE;
        end
      end
      SPC_IDLE: begin
        if (wakeAny) begin
          state_next = SPC_RUN;
        end
      end
      SPC_SLEEP: begin
        if (wakeAny) begin
          state_next = SPC_RUN;
        end
      end
      default: begin
        state_next = SPC_RUN;
      end
    endcase
  end

  assign osc_next = oscWriteOk ? oscWriteSel : osc_reg;

  // rstn returns to run (synchronous); the anyReset wake returns to run through wakeAny
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= SPC_RUN;
      osc_reg <= SPC_OSC_RST;
      sleepOsc_reg <= SPC_OSC_RST;
      wdtClr_reg <= 1'b0;
      irqSvc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      osc_reg <= osc_next;
      if (inRun && enterSleep) begin
        sleepOsc_reg <= osc_reg;
      end
      wdtClr_reg <= inRun && enterSleep && wdtEnable;
      irqSvc_reg <= !inRun && wakeSync_reg.irqReq;
    end
  end

  // ********************************************************************
  // clock gating and outputs
  // ********************************************************************
  assign cpuRun = inRun;
  assign sysClkEn = !inSleep;
  assign periphClkEn = !inSleep;
  assign oscEnable = !inSleep;
  assign curOscSel = inSleep ? sleepOsc_reg : osc_reg;
  assign clkMonEnable = !inSleep;
  assign rcClkEnable = !inSleep || wdtEnable || (calEnable && calUsesRc);
  assign wdtClear = wdtClr_reg;
  assign irqService = irqSvc_reg;
  assign modeOut = inSleep ? 2'h2 : (state_reg == SPC_IDLE) ? 2'h1 : 2'h0;

  spc_io_hold u_hold (
    .clock(clock),
    .rstn(rstn),
    .hold(inSleep),
    .ioIn(ioLive),
    .ioOut(ioPins)
  );

  // ********************************************************************
  // assertion helpers: pin snapshot taken on the first sleep cycle
  // ********************************************************************
  spc_io_t ioSnap_reg;
  logic sleepSeen_reg;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ioSnap_reg <= '0;
      sleepSeen_reg <= 1'b0;
    end else begin
      sleepSeen_reg <= inSleep;
      if (inSleep && !sleepSeen_reg) begin
        ioSnap_reg <= ioPins;
      end
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  sequence s_sleepCmd;
    inRun && enterSleep;
  endsequence

  sequence s_idleCmd;
    inRun && enterIdle;
  endsequence

  sequence s_irqWake;
    !inRun && wakeSync_reg.irqReq;
  endsequence

  property p_sleepClk;
    @(posedge clock) disable iff (!rstn) inSleep |-> !sysClkEn && !cpuRun && !oscEnable;
  endproperty
  a_sleepClk: assert property (p_sleepClk) else $error("clock running in sleep");

  property p_idle;
    @(posedge clock) disable iff (!rstn)
      (state_reg == SPC_IDLE) |-> !cpuRun && periphClkEn && sysClkEn;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong");

  property p_entry;
    @(posedge clock) disable iff (!rstn) s_sleepCmd |=> inSleep;
  endproperty
  a_entry: assert property (p_entry) else $error("sleep not entered");

  property p_noEntry;
    @(posedge clock) disable iff (!rstn) (inRun && !pwrSaveCmd.valid) |=> inRun;
  endproperty
  a_noEntry: assert property (p_noEntry) else $error("mode left without command");

  property p_wake;
    @(posedge clock) disable iff (!rstn) (!inRun && wakeAny) |=> inRun;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_mon;
    @(posedge clock) disable iff (!rstn) inSleep |-> !clkMonEnable;
  endproperty
  a_mon: assert property (p_mon) else $error("clock monitor active in sleep");

  property p_rc;
    @(posedge clock) disable iff (!rstn) (inSleep && wdtEnable) |-> rcClkEnable;
  endproperty
  a_rc: assert property (p_rc) else $error("rc clock stopped with watchdog on");

  property p_wdtClr;
    @(posedge clock) disable iff (!rstn)
      (inRun && enterSleep && wdtEnable) |=> wdtClear && inSleep;
  endproperty
  a_wdtClr: assert property (p_wdtClr) else $error("watchdog not cleared");

  property p_io;
    @(posedge clock) disable iff (!rstn) (inSleep && $past(inSleep)) |-> $stable(ioPins);
  endproperty
  a_io: assert property (p_io) else $error("pins changed in sleep");

  property p_osc;
    @(posedge clock) disable iff (!rstn)
      ((inRun && enterSleep) || inSleep) |=> $stable(curOscSel);
  endproperty
  a_osc: assert property (p_osc) else $error("clock source changed across sleep");

  property p_lock;
    @(posedge clock) disable iff (!rstn) oscLocked |=> $stable(osc_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked clock source changed");

  property p_wdtOnly;
    @(posedge clock) disable iff (!rstn) !(inRun && enterSleep && wdtEnable) |=> !wdtClear;
  endproperty
  a_wdtOnly: assert property (p_wdtOnly) else $error("stray watchdog clear");

  property p_periph;
    @(posedge clock) disable iff (!rstn) inSleep |-> !periphClkEn;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral clock on in sleep");

  property p_rcCal;
    @(posedge clock) disable iff (!rstn) (inSleep && calEnable && calUsesRc) |-> rcClkEnable;
  endproperty
  a_rcCal: assert property (p_rcCal) else $error("rc clock stopped with calendar on");

  property p_runClk;
    @(posedge clock) disable iff (!rstn)
      inRun |-> cpuRun && sysClkEn && periphClkEn && oscEnable && clkMonEnable;
  endproperty
  a_runClk: assert property (p_runClk) else $error("clocks gated in run");

  property p_idleOsc;
    @(posedge clock) disable iff (!rstn) (state_reg == SPC_IDLE) |-> oscEnable && clkMonEnable;
  endproperty
  a_idleOsc: assert property (p_idleOsc) else $error("source stopped in idle");

  property p_idleEntry;
    @(posedge clock) disable iff (!rstn) s_idleCmd |=> (state_reg == SPC_IDLE);
  endproperty
  a_idleEntry: assert property (p_idleEntry) else $error("idle not entered");

  property p_hold;
    @(posedge clock) disable iff (!rstn) (!inRun && !wakeAny) |=> $stable(state_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without wake");

  property p_svc;
    @(posedge clock) disable iff (!rstn) s_irqWake |=> irqService && inRun;
  endproperty
  a_svc: assert property (p_svc) else $error("interrupt not serviced on wake");

  property p_svcRun;
    @(posedge clock) disable iff (!rstn) irqService |-> inRun;
  endproperty
  a_svcRun: assert property (p_svcRun) else $error("service outside run");

  property p_sleepOsc;
    @(posedge clock) disable iff (!rstn) inSleep |=> $stable(osc_reg);
  endproperty
  a_sleepOsc: assert property (p_sleepOsc) else $error("source changed in sleep");

  property p_pinsFollow;
    @(posedge clock) disable iff (!rstn) (rstn && !inSleep) |=> ioPins == $past(ioLive);
  endproperty
  a_pinsFollow: assert property (p_pinsFollow) else $error("pins not following");

  property p_ioSnap;
    @(posedge clock) disable iff (!rstn) (inSleep && sleepSeen_reg) |-> ioPins == ioSnap_reg;
  endproperty
  a_ioSnap: assert property (p_ioSnap) else $error("pins drifted from entry value");

endmodule

// >>> verification/spc_core_model.sv
// spc_core_model: processor core that issues the power-save instruction
`timescale 1ns/1ps
module spc_core_model
  import spc_pkg::*;
(
  input wire logic clock,
  input wire logic issue,
  input wire logic [7:0] opcode,
  output spc_cmd_t cmd
);
  // ********************************************************************
  // one-cycle instruction pulse, operand scrambled when not issuing
  // ********************************************************************
  initial cmd = '0;
  always @(posedge clock) begin
    cmd <= '{valid: issue, operand: issue ? opcode : ~opcode};
  end
endmodule

// >>> verification/sleep_idle_power_controller_tb_top.sv
// sleep_idle_power_controller_tb_top: scenario bench for the power controller
`timescale 1ns/1ps
module sleep_idle_power_controller_tb_top
  import spc_pkg::*;
;
  logic clock = 0, rstn = 0, issue = 0, wdtEnable = 0, calEnable = 0, calUsesRc = 0;
  logic oscWrite = 0, oscLocked = 0, cpuRun, sysClkEn, periphClkEn, oscEnable;
  logic clkMonEnable, rcClkEnable, wdtClear, irqService, svc;
  logic [7:0] opcode = 8'h00;
  logic [2:0] oscWriteSel = 3'h0, curOscSel;
  logic [1:0] modeOut;
  spc_cmd_t cmd;
  spc_wake_t wakeIn = '0;
  spc_io_t ioLive = '0, ioPins;
  int failures = 0, numChecks = 0;
  always #2.5 clock = ~clock;
  spc_core_model spc_core_model_inst (.clock(clock), .issue(issue), .opcode(opcode), .cmd(cmd));
  spc_power_ctrl spc_power_ctrl_inst (.clock(clock), .rstn(rstn), .pwrSaveCmd(cmd),
    .wakeIn(wakeIn), .wdtEnable(wdtEnable), .calEnable(calEnable), .calUsesRc(calUsesRc),
    .oscWrite(oscWrite), .oscWriteSel(oscWriteSel), .oscLocked(oscLocked), .ioLive(ioLive),
    .ioPins(ioPins), .cpuRun(cpuRun), .sysClkEn(sysClkEn), .periphClkEn(periphClkEn),
    .oscEnable(oscEnable), .curOscSel(curOscSel), .clkMonEnable(clkMonEnable),
    .rcClkEnable(rcClkEnable), .wdtClear(wdtClear), .irqService(irqService),
    .modeOut(modeOut));
  // ********************************************************************
  // helpers
  // ********************************************************************
  task automatic stop_test();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    numChecks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  // called just after a rising edge; returns settled after the taking edge
  task automatic cmdGo(input logic [7:0] op);
    opcode <= op;
    issue <= 1'b1;
    @(posedge clock);
    issue <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic waitRun();
    svc = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      #1;
      svc |= irqService === 1'b1;
      if (cpuRun === 1'b1) return;
    end
    failures++;
    $display("unexpected %0t no wake", $time);
    stop_test();
  endtask
  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic testOsc();
    @(posedge clock);
    oscLocked <= 1'b1;
    oscWriteSel <= 3'h3;
    oscWrite <= 1'b1;
    @(posedge clock);
    oscLocked <= 1'b0;
    oscWriteSel <= 3'h5;
    #1;
    chk(curOscSel === 3'h0, "locked write taken");
    @(posedge clock);
    oscWrite <= 1'b0;
    #1;
    chk(curOscSel === 3'h5, "unlocked write lost");
    $display("osc switch done");
  endtask
  task automatic testSleep();
    @(posedge clock);
    ioLive <= 32'hA5A50F0F;
    wdtEnable <= 1'b1;
    @(posedge clock);
    cmdGo(SPC_OP_SLEEP);
    chk(modeOut === 2'h2 && cpuRun === 1'b0, "no sleep");
    chk({sysClkEn, periphClkEn, oscEnable, clkMonEnable} === 4'h0, "clocks on");
    chk(wdtClear === 1'b1 && rcClkEnable === 1'b1, "wdt entry");
    @(posedge clock);
    ioLive <= 32'h5A5AF0F0;
    wdtEnable <= 1'b0;
    calEnable <= 1'b1;
    calUsesRc <= 1'b1;
    oscWrite <= 1'b1;
    oscWriteSel <= 3'h2;
    #1;
    chk(wdtClear === 1'b0 && rcClkEnable === 1'b1, "clear or rc");
    @(posedge clock);
    oscWrite <= 1'b0;
    calEnable <= 1'b0;
    #1;
    chk(rcClkEnable === 1'b0 && ioPins === 32'hA5A50F0F, "rc or pins");
    @(posedge clock);
    wakeIn.irqReq <= 1'b1;
    waitRun();
    chk(svc && modeOut === 2'h0 && curOscSel === 3'h5, "irq wake");
    @(posedge clock);
    wakeIn.irqReq <= 1'b0;
    #1;
    chk(ioPins === 32'h5A5AF0F0, "pins stuck");
    $display("sleep done");
  endtask
  task automatic testIdle();
    repeat (4) @(posedge clock);
    cmdGo(SPC_OP_IDLE);
    chk(modeOut === 2'h1 && cpuRun === 1'b0, "no idle");
    chk(sysClkEn === 1'b1 && periphClkEn === 1'b1, "idle clocks");
    cmdGo(SPC_OP_SLEEP);
    chk(modeOut === 2'h1, "command in idle");
    @(posedge clock);
    wakeIn.wdtTimeout <= 1'b1;
    waitRun();
    chk(!svc && modeOut === 2'h0, "wdt wake");
    @(posedge clock);
    wakeIn.wdtTimeout <= 1'b0;
    cmdGo(8'h05);
    chk(modeOut === 2'h0 && cpuRun === 1'b1, "bad operand");
    $display("idle done");
  endtask
  task automatic testReset();
    @(posedge clock);
    cmdGo(SPC_OP_SLEEP);
    @(posedge clock);
    wakeIn.anyReset <= 1'b1;
    waitRun();
    chk(!svc && modeOut === 2'h0, "reset source wake");
    @(posedge clock);
    wakeIn.anyReset <= 1'b0;
    cmdGo(SPC_OP_IDLE);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk(modeOut === 2'h0 && cpuRun === 1'b1 && curOscSel === SPC_OSC_RST, "reset wake");
    $display("reset done");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1;
    chk(modeOut === 2'h0 && ioPins.dir === SPC_IO_RST && ioPins.out === SPC_IO_RST
      && curOscSel === SPC_OSC_RST, "reset");
    @(posedge clock);
    rstn <= 1'b1;
    testOsc();
    testSleep();
    testIdle();
    testReset();
    stop_test();
  end
endmodule
